// ---- src/icf_map.vh ----
`ifndef ICF_MAP_VH
`define ICF_MAP_VH

// ==========================================================
// register byte offsets
`define ICF_OFS_MODE      8'h00
`define ICF_OFS_STATUS    8'h04
`define ICF_OFS_CLK_LOW   8'h08
`define ICF_OFS_CLK_HIGH  8'h0c
`define ICF_OFS_COUNT     8'h10
`define ICF_OFS_SRC_CODE  8'h14

// ==========================================================
// status register bit positions
`define ICF_ST_AL         0
`define ICF_ST_NACK       1
`define ICF_ST_REGISTER_ACCESS_READY_FLAG       2
`define ICF_ST_BB         12

// ==========================================================
// mode register bit positions
`define ICF_MD_RM         7
`define ICF_MD_IRS        5
`define ICF_MD_TRX        9
`define ICF_MD_MST        10
`define ICF_MD_STP        11
`define ICF_MD_STT        13

// ==========================================================
// interrupt source codes
`define ICF_CODE_NONE     3'h0
`define ICF_CODE_AL       3'h1
`define ICF_CODE_NACK     3'h2
`define ICF_CODE_REGISTER_ACCESS_READY_FLAG     3'h3

// ==========================================================
// reset values and timing
`define ICF_RST_MODE      16'h0000
`define ICF_RST_DIV       16'h0000
`define ICF_RST_COUNT     16'h0000
`define ICF_D_OFFSET      5

`endif

// ---- src/icf_ctrl.v ----
// Contract
// R1: writing one to the nack status bit clears the nack flag.
// R2: reading source code register holding nack code clears the nack flag.
// R3: module reset bit low or processor reset clears nack and arbitration flags.
// R4: transmitter sees not-acknowledge in ack slot, nack flag is set.
// R5: during general call the nack flag is set even when slaves acknowledge.
// R6: writing one to the arbitration status bit clears the arbitration flag.
// R7: reading source code register holding arbitration code clears that flag.
// R8: master-transmitter losing arbitration sets the arbitration flag.
// R9: start attempt while bus busy also sets the arbitration flag.
// R10: arbitration loss clears master and stop bits; device becomes slave receiver.
// R11: master holds clock low for low divide value plus offset d cycles.
// R12: master holds clock high for high divide value plus offset d cycles; the code releases it two cycles longer.
// R13: software programs both dividers only while module reset bit is zero.
// R14: each divider holds a sixteen bit value in bits fifteen to zero.
// R15: divider bits thirty-one to sixteen read zero and ignore writes.
// R16: word count used only for master transmit without repeat mode.
// R17: count copied to internal counter, decremented per word, register unchanged.
// R18: with stop requested, stop is generated when the countdown completes.
// R19: programmed count zero loads 65536, others load their own value.
// R20: non-repeat, no stop: ready flag set when internal counter reaches zero.
// R21: offset d is a design parameter tied to the prescaler setting.
//
// Our own choices: register access over APB and the register addresses.
`include "icf_map.vh"

// ==========================================================
// overview
// register side: plain apb slave, zero wait states, byte addresses
// line side: event pulses from the shifter on the same clock
// the shifter itself, data registers and prescaler live elsewhere
// only the serial clock pin is asynchronous and gets two flops
// all status flags share one rule: a set event beats a clear
// module reset bit low holds every flag and both counters idle
// limitation: dividers are writable any time; software keeps
// them stable while running, otherwise a phase may be cut short
// the start request bit is self clearing and always reads zero
// a start is only honoured while the module reset bit is already one
// trade-off: read data is captured in the setup cycle, so the
// clear on read acts on exactly the code the reader was shown
// and no flag can be lost between capture and clear

module icf_ctrl #(
  parameter integer D_OFFSET = `ICF_D_OFFSET  // R21
) (
  input  wire        SYS_CLK_I,
  input  wire        ARST_N_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output wire [31:0] PRDATA_O,
  output wire        PREADY_O,
  output wire        PSLVERR_O,
  input  wire        BUS_BUSY_I,
  input  wire        TX_ACTIVE_I,
  input  wire        ACK_SLOT_I,
  input  wire        ACK_NACK_I,
  input  wire        GEN_CALL_I,
  input  wire        ARB_LOSS_I,
  input  wire        WORD_DONE_I,
  input  wire        SCL_I,
  output wire        SCL_O,
  output wire        SCL_OE_N_O,
  output wire        START_O,
  output wire        STOP_O,
  output wire        MASTER_O
);

  // ==========================================================
  // state and decode
  reg  [15:0] mode_ff;
  reg  [15:0] clk_low_ff;
  reg  [15:0] clk_high_ff;
  reg  [15:0] count_reg_ff;
  reg         al_ff;
  reg         nack_ff;
  reg         register_access_ready_flag_ff;
  reg  [16:0] word_cnt_ff;
  reg         cnt_run_ff;
  reg         start_ff;
  reg         stop_ff;
  reg  [31:0] rdata_ff;
  reg         err_ff;
  reg  [2:0]  code_rd_ff;
  reg         scl_s1_ff;
  reg         scl_s2_ff;
  reg         scl_low_ff;
  reg  [16:0] div_cnt_ff;

  wire        setup  = PSEL_I & ~PENABLE_I;
  wire        access = PSEL_I & PENABLE_I;
  wire        wr     = access & PWRITE_I;
  wire        rd     = access & ~PWRITE_I;
  wire        wr_mode = wr & (PADDR_I == `ICF_OFS_MODE);
  wire        wr_stat = wr & (PADDR_I == `ICF_OFS_STATUS);
  wire        module_reset_bit    = mode_ff[`ICF_MD_IRS];
  wire        master_select_bit    = mode_ff[`ICF_MD_MST];
  wire        stop_request_bit    = mode_ff[`ICF_MD_STP];
  wire        rm     = mode_ff[`ICF_MD_RM];
  wire        transmit_select_bit    = mode_ff[`ICF_MD_TRX];
  wire        mapped = (PADDR_I == `ICF_OFS_MODE) | (PADDR_I == `ICF_OFS_STATUS) |
                       (PADDR_I == `ICF_OFS_CLK_LOW) | (PADDR_I == `ICF_OFS_CLK_HIGH) |
                       (PADDR_I == `ICF_OFS_COUNT) | (PADDR_I == `ICF_OFS_SRC_CODE);

  // priority: arbitration first, then nack, then ready
  reg  [2:0]  src_code;
  always @*
  begin
    if (al_ff)
      src_code = `ICF_CODE_AL;
    else if (nack_ff)
      src_code = `ICF_CODE_NACK;
    else if (register_access_ready_flag_ff)
      src_code = `ICF_CODE_REGISTER_ACCESS_READY_FLAG;
    else
      src_code = `ICF_CODE_NONE;
  end

  // ==========================================================
  // flag events
  // every event input is a one-cycle pulse on this clock
  // arbitration loss counts only as master transmitter
  // a start on a busy bus is itself an arbitration loss
  // clears come from a write of one or from a source read; ready also clears on an accepted start
  // the source read clears only the flag whose code was shown
  // hazard: a new event in the clearing cycle must survive,
  // hence the set term is or-ed outside the clear term
  // start attempt: software writes start with master selected
  wire        start_try = wr_mode & PWDATA_I[`ICF_MD_STT] & PWDATA_I[`ICF_MD_MST] & module_reset_bit;
  wire        start_bb  = start_try & BUS_BUSY_I;                  // R9
  wire        start_ok  = start_try & ~BUS_BUSY_I;
  wire        arb_set   = (ARB_LOSS_I & master_select_bit & transmit_select_bit) | start_bb;     // R8 R9
  // general call keeps nack up whatever the slaves answer
  wire        nack_set  = TX_ACTIVE_I & ACK_SLOT_I & (ACK_NACK_I | GEN_CALL_I); // R4 R5
  wire        src_rd    = rd & (PADDR_I == `ICF_OFS_SRC_CODE);
  wire        al_clr    = (wr_stat & PWDATA_I[`ICF_ST_AL]) |                   // R6
                          (src_rd & (code_rd_ff == `ICF_CODE_AL));           // R7
  wire        nack_clr  = (wr_stat & PWDATA_I[`ICF_ST_NACK]) |                 // R1
                          (src_rd & (code_rd_ff == `ICF_CODE_NACK));         // R2
  wire        register_access_ready_flag_clr  = (wr_stat & PWDATA_I[`ICF_ST_REGISTER_ACCESS_READY_FLAG]) |
                          (src_rd & (code_rd_ff == `ICF_CODE_REGISTER_ACCESS_READY_FLAG)) | start_ok;

  // countdown completion on the last word
  wire        cnt_last  = cnt_run_ff & WORD_DONE_I & (word_cnt_ff == 17'h00001);
  wire        register_access_ready_flag_set  = (cnt_last & ~stop_request_bit) | (WORD_DONE_I & rm & master_select_bit & transmit_select_bit); // R20

  // set beats clear; module reset bit low holds all flags clear
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      al_ff   <= 1'b0;
      nack_ff <= 1'b0;
      register_access_ready_flag_ff <= 1'b0;
    end
    else if (!module_reset_bit)
    begin
      al_ff   <= 1'b0; // R3
      nack_ff <= 1'b0; // R3
      register_access_ready_flag_ff <= 1'b0;
    end
    else
    begin
      al_ff   <= arb_set  | (al_ff & ~al_clr);
      nack_ff <= nack_set | (nack_ff & ~nack_clr);
      register_access_ready_flag_ff <= register_access_ready_flag_set | (register_access_ready_flag_ff & ~register_access_ready_flag_clr);
    end
  end

  // ==========================================================
  // mode register and dividers
  reg  [15:0] nxt_mode;
  always @*
  begin
    nxt_mode = mode_ff;
    if (wr_mode)
      nxt_mode = PWDATA_I[15:0] & ~(16'h0001 << `ICF_MD_STT);
    if (cnt_last & stop_request_bit)
    begin
      nxt_mode[`ICF_MD_MST] = 1'b0;
      nxt_mode[`ICF_MD_STP] = 1'b0;
    end
    if (module_reset_bit & arb_set)
    begin
      nxt_mode[`ICF_MD_MST] = 1'b0; // R10
      nxt_mode[`ICF_MD_STP] = 1'b0; // R10
      nxt_mode[`ICF_MD_TRX] = 1'b0; // R10
    end
  end

  // dividers are meant to be written only while held in module reset
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      mode_ff      <= `ICF_RST_MODE;
      clk_low_ff   <= `ICF_RST_DIV;
      clk_high_ff  <= `ICF_RST_DIV;
      count_reg_ff <= `ICF_RST_COUNT;
    end
    else
    begin
      mode_ff <= nxt_mode;
      if (wr & (PADDR_I == `ICF_OFS_CLK_LOW))
        clk_low_ff <= PWDATA_I[15:0];  // R13 R14 R15
      if (wr & (PADDR_I == `ICF_OFS_CLK_HIGH))
        clk_high_ff <= PWDATA_I[15:0]; // R13 R14 R15
      if (wr & (PADDR_I == `ICF_OFS_COUNT))
        count_reg_ff <= PWDATA_I[15:0];
    end
  end

  // ==========================================================
  // internal word counter
  // loaded on an accepted start as master transmitter, non-repeat
  // the count register itself is never touched by the countdown
  // seventeen bits so that a programmed zero can mean 65536
  // repeat mode freezes the countdown; ready then follows each word
  // an arbitration loss or module reset abandons the countdown
  // stop pulse is registered: one cycle after the last word
  // limitation: a restart while counting simply reloads the count
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      word_cnt_ff <= 17'h00000;
      cnt_run_ff  <= 1'b0;
      start_ff    <= 1'b0;
      stop_ff     <= 1'b0;
    end
    else
    begin
      start_ff <= start_ok & module_reset_bit;
      stop_ff  <= module_reset_bit & cnt_last & stop_request_bit;            // R18
      if (!module_reset_bit | arb_set)
        cnt_run_ff <= 1'b0;
      else if (start_ok & PWDATA_I[`ICF_MD_TRX] & ~PWDATA_I[`ICF_MD_RM])  // R16
      begin
        cnt_run_ff  <= 1'b1;
        word_cnt_ff <= (count_reg_ff == 16'h0000) ? 17'h10000 :
                       {1'b0, count_reg_ff};       // R17 R19
      end
      else if (cnt_run_ff & WORD_DONE_I & ~rm)     // R16
      begin
        word_cnt_ff <= word_cnt_ff - 17'h00001;    // R17
        if (word_cnt_ff == 17'h00001)
          cnt_run_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // serial clock divider
  // one shared counter serves both phases; it restarts at each edge
  // the first phase after enabling is high, so the line idles high
  // low phase is fixed length: the pin is ours while we pull it
  // high phase counts only while the synchronised pin reads high,
  // so a slave holding the line low stretches the cycle
  // trade-off: the two flop delay lengthens every high phase after a low
  // phase by two cycles, stretched or not, accepted for metastability safety
  // the pin is synchronised before use; a slave stretching low delays the high phase
  wire [16:0] low_len  = {1'b0, clk_low_ff} + D_OFFSET[16:0];   // R11 R21
  wire [16:0] high_len = {1'b0, clk_high_ff} + D_OFFSET[16:0];  // R12 R21
  wire        scl_run  = module_reset_bit & master_select_bit;

  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      scl_s1_ff  <= 1'b1;
      scl_s2_ff  <= 1'b1;
      scl_low_ff <= 1'b0;
      div_cnt_ff <= 17'h00000;
    end
    else
    begin
      scl_s1_ff <= SCL_I;
      scl_s2_ff <= scl_s1_ff;
      if (!scl_run)
      begin
        scl_low_ff <= 1'b0;
        div_cnt_ff <= 17'h00000;
      end
      else if (scl_low_ff)
      begin
        if (div_cnt_ff >= low_len - 17'h00001)      // R11
        begin
          scl_low_ff <= 1'b0;
          div_cnt_ff <= 17'h00000;
        end
        else
          div_cnt_ff <= div_cnt_ff + 17'h00001;
      end
      else if (scl_s2_ff)
      begin
        if (div_cnt_ff >= high_len - 17'h00001)     // R12
        begin
          scl_low_ff <= 1'b1;
          div_cnt_ff <= 17'h00000;
        end
        else
          div_cnt_ff <= div_cnt_ff + 17'h00001;
      end
    end
  end

  // ==========================================================
  // apb read path, data captured in the setup cycle
  // reserved upper halves always read zero
  // status shows the live bus busy level in its own bit
  // unmapped addresses read zero and raise the slave error
  // writes return zero data; the capture still runs for them and loads zero
  // the source code register has priority arbitration, nack, ready
  reg  [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h00000000;
    case (PADDR_I)
      `ICF_OFS_MODE:     rd_mux = {16'h0000, mode_ff};
      `ICF_OFS_STATUS:   rd_mux = ({31'h0, al_ff} << `ICF_ST_AL) |
                                  ({31'h0, nack_ff} << `ICF_ST_NACK) |
                                  ({31'h0, register_access_ready_flag_ff} << `ICF_ST_REGISTER_ACCESS_READY_FLAG) |
                                  ({31'h0, BUS_BUSY_I} << `ICF_ST_BB);
      `ICF_OFS_CLK_LOW:  rd_mux = {16'h0000, clk_low_ff};   // R15
      `ICF_OFS_CLK_HIGH: rd_mux = {16'h0000, clk_high_ff};  // R15
      `ICF_OFS_COUNT:    rd_mux = {16'h0000, count_reg_ff}; // R17
      `ICF_OFS_SRC_CODE: rd_mux = {29'h0, src_code};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  // the clear on read acts on the code the reader actually sees
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      rdata_ff   <= 32'h00000000;
      err_ff     <= 1'b0;
      code_rd_ff <= `ICF_CODE_NONE;
    end
    else if (setup)
    begin
      rdata_ff   <= PWRITE_I ? 32'h00000000 : rd_mux;
      err_ff     <= ~mapped;
      code_rd_ff <= src_code;
    end
  end

  // ==========================================================
  // outputs
  // ready is tied high: every transfer finishes in its access cycle
  // clock pin is open drain: only the enable moves, data stays zero
  // start, stop and master come straight from registers
  assign PRDATA_O   = rdata_ff;
  assign PREADY_O   = 1'b1;
  assign PSLVERR_O  = access & err_ff;
  assign SCL_O      = 1'b0;
  assign SCL_OE_N_O = ~(scl_run & scl_low_ff);
  assign START_O    = start_ff;
  assign STOP_O     = stop_ff;
  assign MASTER_O   = master_select_bit;

endmodule // icf_ctrl

// ---- bench/icf_bus_model.sv ----
module icf_bus_model (
  input  wire scl_drv_i,
  input  wire scl_oe_n_i,
  input  wire stretch_i,
  output wire scl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // shared clock wire
  // pull-up when released; a slow slave holds it low to stretch
  assign scl_o = (scl_oe_n_i ? 1'b1 : scl_drv_i) & ~stretch_i;
endmodule // icf_bus_model

// ---- bench/icf_ctrl_asserts.sv ----
`include "icf_map.vh"
module icf_ctrl_asserts #(
  parameter integer D_OFFSET = `ICF_D_OFFSET
) (
  input wire        SYS_CLK_I,
  input wire        ARST_N_I,
  input wire        PSEL_I,
  input wire        PENABLE_I,
  input wire        PWRITE_I,
  input wire [7:0]  PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [31:0] PRDATA_O,
  input wire        BUS_BUSY_I,
  input wire        ARB_LOSS_I,
  input wire        WORD_DONE_I,
  input wire        SCL_I,
  input wire        SCL_OE_N_O,
  input wire        START_O,
  input wire        STOP_O,
  input wire        MASTER_O
);
  timeunit 1ns;
  timeprecision 1ns;
  wire        wr = PSEL_I & PENABLE_I & PWRITE_I;
  wire        rd = PSEL_I & PENABLE_I & ~PWRITE_I;
  reg  [15:0] lo_ff, hi_ff;
  reg  [17:0] lo_cnt_ff, hi_cnt_ff;
  reg         irs_ff, trx_ff, sy1_ff, sy2_ff;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // ========
  // shadow of bus writes and phase lengths
  // own two-flop copy of the pin, so stretched cycles are not counted
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      {lo_ff, hi_ff, irs_ff, trx_ff, sy1_ff, sy2_ff} <= {`ICF_RST_DIV, `ICF_RST_DIV, 4'h0};
      lo_cnt_ff <= 18'h0;
      hi_cnt_ff <= 18'h0;
    end
    else
    begin
      if (wr && PADDR_I == `ICF_OFS_CLK_LOW) lo_ff <= PWDATA_I[15:0];
      if (wr && PADDR_I == `ICF_OFS_CLK_HIGH) hi_ff <= PWDATA_I[15:0];
      if (wr && PADDR_I == `ICF_OFS_MODE) irs_ff <= PWDATA_I[`ICF_MD_IRS];
      if (wr && PADDR_I == `ICF_OFS_MODE) trx_ff <= PWDATA_I[`ICF_MD_TRX];
      sy1_ff <= SCL_I;
      sy2_ff <= sy1_ff;
      lo_cnt_ff <= SCL_OE_N_O ? 18'h0 : lo_cnt_ff + 18'h1;
      hi_cnt_ff <= (!SCL_OE_N_O || !MASTER_O) ? 18'h0 : hi_cnt_ff + {17'h0, sy2_ff};
    end
  end
  // ========
  // request shapes
  sequence s_start_req;
    wr && PADDR_I == `ICF_OFS_MODE && PWDATA_I[`ICF_MD_IRS] && irs_ff
      && PWDATA_I[`ICF_MD_MST] && PWDATA_I[`ICF_MD_STT];
  endsequence
  sequence s_div_read;
    rd && (PADDR_I == `ICF_OFS_CLK_LOW || PADDR_I == `ICF_OFS_CLK_HIGH);
  endsequence
  // ========
  // checks
  a_busy_start_lost:
  assert property (s_start_req ##0 BUS_BUSY_I |=> !MASTER_O && !START_O) else $error("busy start");
  a_arb_drops_master:
  assert property (ARB_LOSS_I && MASTER_O && trx_ff && irs_ff |=> !MASTER_O) else $error("arb");
  a_low_phase_len:
  assert property ($rose(SCL_OE_N_O) && MASTER_O && irs_ff |-> lo_cnt_ff == lo_ff + D_OFFSET)
    else $error("low phase");
  a_high_phase_len:
  assert property ($fell(SCL_OE_N_O) && MASTER_O && irs_ff |-> hi_cnt_ff + 1 >= hi_ff + D_OFFSET
    && hi_cnt_ff <= hi_ff + D_OFFSET + 1) else $error("high phase");
  a_div_upper_zero:
  assert property (s_div_read |-> PRDATA_O[31:16] == 16'h0) else $error("divider upper bits");
  a_reset_flags_zero:
  assert property (rd && PADDR_I == `ICF_OFS_STATUS && !irs_ff |-> PRDATA_O[1:0] == 2'h0)
    else $error("flags in reset");
  a_stop_one_cycle:
  assert property ($rose(STOP_O) |=> !STOP_O) else $error("stop width");
  a_stop_after_word:
  assert property ($rose(STOP_O) |-> !MASTER_O && ($past(WORD_DONE_I) || $past(WORD_DONE_I, 2)))
    else $error("stop cause");
endmodule // icf_ctrl_asserts

bind icf_ctrl icf_ctrl_asserts #(.D_OFFSET(D_OFFSET)) u_icf_chk (
  .SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .BUS_BUSY_I(BUS_BUSY_I), .ARB_LOSS_I(ARB_LOSS_I), .WORD_DONE_I(WORD_DONE_I),
  .SCL_I(SCL_I), .SCL_OE_N_O(SCL_OE_N_O), .START_O(START_O), .STOP_O(STOP_O),
  .MASTER_O(MASTER_O));

// ---- bench/icf_ctrl_tb_top.sv ----
`include "icf_map.vh"
module icf_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] M_ON = 32'h1 << `ICF_MD_IRS;
  localparam logic [31:0] M_MS = 32'h1 << `ICF_MD_MST;
  localparam logic [31:0] M_SP = 32'h1 << `ICF_MD_STP;
  localparam logic [31:0] M_RP = 32'h1 << `ICF_MD_RM;
  localparam logic [31:0] M_RUN = M_ON | M_MS | (32'h1 << `ICF_MD_TRX) | (32'h1 << `ICF_MD_STT);
  logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
  logic        busy = 1'b0, tx = 1'b0, slot = 1'b0, nack = 1'b0, gcall = 1'b0;
  logic        arb = 1'b0, word = 1'b0, hold = 1'b0;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, scl_drv, scl_oe_n, scl, stop, master;
  int          n_errors = 0, num_checks = 0, n_stop = 0, s0;
  logic [7:0]  regs [3] = '{`ICF_OFS_CLK_LOW, `ICF_OFS_CLK_HIGH, `ICF_OFS_COUNT};
  // count table: programmed count, extra mode bits, words, {ready, stops}
  logic [15:0] t_cnt [6] = '{16'h2, 16'h2, 16'h2, 16'h0, 16'h2, 16'h1};
  logic [31:0] t_md [6] = '{M_SP, 32'h0, 32'h0, 32'h0, M_RP, M_SP};
  int          t_np [6] = '{2, 1, 2, 2, 1, 1};
  logic [1:0]  t_exp [6] = '{2'b01, 2'b00, 2'b10, 2'b00, 2'b10, 2'b01};

  icf_ctrl #(.D_OFFSET(3)) i_dut (
    .SYS_CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(addr), .PWDATA_I(wdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .BUS_BUSY_I(busy), .TX_ACTIVE_I(tx), .ACK_SLOT_I(slot),
    .ACK_NACK_I(nack), .GEN_CALL_I(gcall), .ARB_LOSS_I(arb), .WORD_DONE_I(word),
    .SCL_I(scl), .SCL_O(scl_drv), .SCL_OE_N_O(scl_oe_n), .START_O(), .STOP_O(stop),
    .MASTER_O(master));
  icf_bus_model i_bus (.scl_drv_i(scl_drv), .scl_oe_n_i(scl_oe_n), .stretch_i(hold), .scl_o(scl));

  // ========
  // clock, stop counter, helpers
  always #25 clk = ~clk;
  always @(posedge clk)
    if (stop === 1'b1)
      n_stop <= n_stop + 1;
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one transfer; a silent slave is left to the watchdog
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // one-cycle event pulse: {ack slot, arbitration loss, word done}
  task pulse(input logic [2:0] k);
    @(posedge clk);
    {slot, arb, word} <= k;
    @(posedge clk);
    {slot, arb, word} <= 3'h0;
  endtask
  task summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // whole run is near three hundred cycles; over sixty times that means a hang
  initial
  begin
    #(20000 * 50);
    n_errors++;
    summarize();
  end
  // ========
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    foreach (regs[i])
    begin
      apb(1'b0, regs[i], 32'h0);
      chk("reset value", rd, {16'h0, `ICF_RST_DIV});
      apb(1'b1, regs[i], 32'hffff_0003 + i);
      apb(1'b0, regs[i], 32'h0);
      chk("divider value", rd, 32'h3 + i);
    end
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", {rd[31:1], err}, 32'h1);
    // serial clock runs; the slave stretches once
    apb(1'b1, `ICF_OFS_MODE, M_ON | M_MS);
    repeat (40) @(posedge clk);
    hold <= 1'b1;
    repeat (9) @(posedge clk);
    hold <= 1'b0;
    repeat (40) @(posedge clk);
    // arbitration loss, then a start on a busy bus
    apb(1'b1, `ICF_OFS_MODE, M_RUN | M_SP);
    pulse(3'b010);
    apb(1'b0, `ICF_OFS_MODE, 32'h0);
    chk("mode after loss", rd & (M_MS | M_SP), 32'h0);
    apb(1'b0, `ICF_OFS_SRC_CODE, 32'h0);
    chk("source code", rd, `ICF_CODE_AL);
    apb(1'b0, `ICF_OFS_STATUS, 32'h0);
    chk("lost by read", rd[`ICF_ST_AL], 1'b0);
    busy <= 1'b1;
    apb(1'b1, `ICF_OFS_MODE, M_ON | M_MS | (32'h1 << `ICF_MD_STT));
    apb(1'b0, `ICF_OFS_STATUS, 32'h0);
    chk("busy start", {rd[`ICF_ST_BB], rd[`ICF_ST_AL]}, 2'b11);
    apb(1'b1, `ICF_OFS_STATUS, 32'h1 << `ICF_ST_AL);
    apb(1'b0, `ICF_OFS_STATUS, 32'h0);
    chk("lost by write", rd[`ICF_ST_AL], 1'b0);
    busy <= 1'b0;
    // not-acknowledge flag and its clears
    tx <= 1'b1;
    nack <= 1'b1;
    pulse(3'b100);
    apb(1'b0, `ICF_OFS_SRC_CODE, 32'h0);
    chk("source code", rd, `ICF_CODE_NACK);
    apb(1'b0, `ICF_OFS_STATUS, 32'h0);
    chk("nack by read", rd[`ICF_ST_NACK], 1'b0);
    pulse(3'b100);
    apb(1'b1, `ICF_OFS_STATUS, 32'h1 << `ICF_ST_NACK);
    apb(1'b0, `ICF_OFS_STATUS, 32'h0);
    chk("nack by write", rd[`ICF_ST_NACK], 1'b0);
    gcall <= 1'b1;
    nack <= 1'b0;
    pulse(3'b100);
    apb(1'b0, `ICF_OFS_STATUS, 32'h0);
    chk("general call", rd[`ICF_ST_NACK], 1'b1);
    apb(1'b1, `ICF_OFS_MODE, 32'h0);
    apb(1'b0, `ICF_OFS_STATUS, 32'h0);
    chk("module reset", rd[1:0], 2'h0);
    gcall <= 1'b0;
    // leave module reset first: a start only counts once the module is running
    apb(1'b1, `ICF_OFS_MODE, M_ON);
    // word countdown, stop and ready
    foreach (t_cnt[i])
    begin
      apb(1'b1, `ICF_OFS_COUNT, {16'h0, t_cnt[i]});
      apb(1'b1, `ICF_OFS_MODE, M_RUN | t_md[i]);
      s0 = n_stop;
      repeat (t_np[i]) pulse(3'b001);
      repeat (3) @(posedge clk);
      apb(1'b0, `ICF_OFS_STATUS, 32'h0);
      chk("ready flag", rd[`ICF_ST_REGISTER_ACCESS_READY_FLAG], t_exp[i][1]);
      chk("stop count", n_stop - s0, t_exp[i][0]);
      apb(1'b0, `ICF_OFS_COUNT, 32'h0);
      chk("count kept", rd, {16'h0, t_cnt[i]});
    end
    // processor reset in mid-run
    nack <= 1'b1;
    pulse(3'b100);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, `ICF_OFS_STATUS, 32'h0);
    chk("processor reset", rd[1:0], 2'h0);
    summarize();
  end
endmodule // icf_ctrl_tb_top
